/* File: acs_cell.sv */
`timescale 1ns/1ps

// One add-compare-select: picks the cheaper of the two paths into a state
module acs_cell
    import vd_pkg::*;
(
    input wire logic [vd_pkg::METRIC_W-1:0] metric_zero,
    input wire logic [vd_pkg::METRIC_W-1:0] metric_one,
    input wire logic [vd_pkg::METRIC_W-1:0] branch_zero,
    input wire logic [vd_pkg::METRIC_W-1:0] branch_one,
    output logic [vd_pkg::SUM_W-1:0] sum_best,
    output logic pick_one
);

    logic [SUM_W-1:0] sum_zero;
    logic [SUM_W-1:0] sum_one;

    // Full-width sums; clamping happens after normalisation in the caller
    assign sum_zero = {1'b0, metric_zero} + {1'b0, branch_zero};
    assign sum_one = {1'b0, metric_one} + {1'b0, branch_one};

    // Ties go to the even predecessor
    assign pick_one = (sum_one < sum_zero);
    assign sum_best = pick_one ? sum_one : sum_zero;

endmodule // acs_cell

/* File: demod_model.sv */
`timescale 1ns/1ps

// Demodulator stand-in: encodes command bits and hands out soft symbols
module demod_model
    import vd_pkg::*;
#(
    parameter int GAP = 4
)
(
    input wire logic clk,
    output logic sym_valid,
    output logic [vd_pkg::SYM_W-1:0] sym_data
);
    logic [5:0] enc_reg;

    initial
    begin
        enc_reg = 6'h00;
        sym_valid = 1'b0;
        sym_data = 3'h0;
    end

    // One confident symbol; line shows the inverse once it is no longer valid
    task automatic put_sym(input logic s);
        @(posedge clk);
        sym_valid <= 1'b1;
        sym_data <= s ? SYM_MAX : 3'h0;
        @(posedge clk);
        sym_valid <= 1'b0;
        sym_data <= s ? 3'h0 : SYM_MAX;
        repeat (GAP - 2) @(posedge clk);
    endtask

    // Two symbols on adjacent edges; far too close, so the pacing check must trip
    task automatic put_burst();
        @(posedge clk);
        sym_valid <= 1'b1;
        sym_data <= 3'h0;
        @(posedge clk);
        sym_data <= SYM_MAX;
        @(posedge clk);
        sym_valid <= 1'b0;
    endtask

    // Two symbols per bit, 171 first then 133; flip makes the first wrong
    task automatic send_bit(input logic u, input logic flip);
        logic [6:0] full;
        full = {u, enc_reg};
        put_sym(^(full & POLY_A) ^ flip);
        put_sym(^(full & POLY_B));
        enc_reg = {u, enc_reg[5:1]};
    endtask
endmodule // demod_model

/* File: uplink_viterbi_command_decoder.sv */
`timescale 1ns/1ps

// Overview of operation
// - Rate one-half code: two received symbols yield one decoded command bit.
// - Constraint length seven: sixty-four trellis states updated in parallel per pair.
// - Each state keeps the incoming path with the better accumulated metric.
// - Path metrics are four bits wide and saturate instead of wrapping.
// - Input symbols are three-bit soft values; branch metrics come from them.
// - Survivor memory is five constraint lengths deep; bits leave after that delay.
// - Command bits run at 2000 bps; symbols arrive at twice that rate.
// - While squelch holds, every command output is driven to logic zero.
// - Squelch takes effect within 15 ms after the subcarrier is lost.
// - Carrier acquisition moves power mode from standby to operate and signals it.
module uplink_viterbi_command_decoder
    import vd_pkg::*;
#(
    parameter int SQUELCH_CYCLES = int'(vd_pkg::SQUELCH_CYC),
    parameter int SYM_MIN_GAP = int'(vd_pkg::SYM_MIN_GAP_CYC)
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic sym_valid,
    input wire logic [vd_pkg::SYM_W-1:0] sym_data,
    input wire logic subcarrier_ok,
    input wire logic carrier_acquired,
    output logic cmd_data,
    output logic cmd_strobe,
    output logic squelch_active,
    output logic power_operate,
    output logic sym_rate_fault
);

    import vd_pkg::*;

    // Symbol pairing
    logic pair_phase_reg;
    logic [SYM_W-1:0] first_sym_reg;
    logic pair_ready;

    // Trellis state
    logic [METRIC_W-1:0] metric_reg [NUM_STATES];
    logic [METRIC_W-1:0] metric_next [NUM_STATES];
    logic [PATH_W-1:0] path_reg [NUM_STATES];
    logic [PATH_W-1:0] path_next [NUM_STATES];
    logic [SUM_W-1:0] sum_best [NUM_STATES];
    logic pick_one [NUM_STATES];
    logic [METRIC_W-1:0] branch_metric [4];
    logic [SUM_W-1:0] sum_min;
    logic [STATE_W-1:0] best_state;
    logic released_bit;

    // Fill, squelch, pacing
    logic [FILL_W-1:0] fill_reg;
    logic filled;
    logic [SQL_CNT_W-1:0] loss_cnt_reg;
    logic [GAP_CNT_W-1:0] gap_cnt_reg;

    // Second symbol of a pair triggers one trellis step
    assign pair_ready = sym_valid && pair_phase_reg;

    // Pair phase toggles per symbol; the first symbol is held until its partner arrives
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pair_phase_reg <= 1'b0;
            first_sym_reg <= '0;
        end
        else if (clk_en && sym_valid)
        begin
            pair_phase_reg <= ~pair_phase_reg;
            if (!pair_phase_reg)
            begin
                first_sym_reg <= sym_data;
            end
        end
    end

    // Branch metrics for the four code pairs; 0 is a confident zero, 7 a confident one
    generate
        for (genvar c = 0; c < 4; c++)
        begin : g_branch
            // Code pair as a sized constant, so its bits can be picked without selecting from a genvar
            localparam logic [1:0] CODE = 2'(c);
            logic [SYM_W-1:0] dist_a;
            logic [SYM_W-1:0] dist_b;
            assign dist_a = CODE[1] ? (SYM_MAX - first_sym_reg) : first_sym_reg;
            assign dist_b = CODE[0] ? (SYM_MAX - sym_data) : sym_data;
            assign branch_metric[c] = {1'b0, dist_a} + {1'b0, dist_b};
        end
    endgenerate

    // One ACS per state; state holds the last six inputs, newest in bit 5
    generate
        for (genvar s = 0; s < NUM_STATES; s++)
        begin : g_state
            localparam logic [STATE_W-1:0] NS = STATE_W'(s);
            localparam logic [STATE_W-1:0] PRED0 = {NS[STATE_W-2:0], 1'b0};
            localparam logic [STATE_W-1:0] PRED1 = {NS[STATE_W-2:0], 1'b1};
            // Expected symbols per branch from the fixed generators
            localparam logic [1:0] CW0 = encode({NS[STATE_W-1], PRED0});
            localparam logic [1:0] CW1 = encode({NS[STATE_W-1], PRED1});

            acs_cell u_acs (
                .metric_zero(metric_reg[PRED0]),
                .metric_one(metric_reg[PRED1]),
                .branch_zero(branch_metric[CW0]),
                .branch_one(branch_metric[CW1]),
                .sum_best(sum_best[s]),
                .pick_one(pick_one[s])
            );

            // Register exchange: inherit the winner's history, append this step's bit
            assign path_next[s] = pick_one[s]
                ? {path_reg[PRED1][PATH_W-2:0], NS[STATE_W-1]}
                : {path_reg[PRED0][PATH_W-2:0], NS[STATE_W-1]};
        end
    endgenerate

    // Smallest survivor sum and its state; used to normalise and to pick the output path
    always_comb
    begin
        sum_min = sum_best[0];
        best_state = '0;
        for (int i = 1; i < NUM_STATES; i++)
        begin
            if (sum_best[i] < sum_min)
            begin
                sum_min = sum_best[i];
                best_state = STATE_W'(i);
            end
        end
    end

    // Normalise by the minimum, then clamp; four bits lose detail on bad channels by design
    always_comb
    begin
        logic [SUM_W-1:0] diff;
        diff = '0;
        for (int i = 0; i < NUM_STATES; i++)
        begin
            diff = sum_best[i] - sum_min;
            if (diff > {1'b0, METRIC_MAX})
            begin
                metric_next[i] = METRIC_MAX;
            end
            else
            begin
                metric_next[i] = diff[METRIC_W-1:0];
            end
        end
    end

    // Oldest bit on the best path, a full path delay behind the newest pair
    assign released_bit = path_next[best_state][PATH_W-1];

    // Metric update, one step per symbol pair
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_STATES; i++)
            begin
                metric_reg[i] <= METRIC_RESET;
            end
        end
        else if (clk_en && pair_ready)
        begin
            for (int i = 0; i < NUM_STATES; i++)
            begin
                metric_reg[i] <= metric_next[i];
            end
        end
    end

    // Survivor memory update
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_STATES; i++)
            begin
                path_reg[i] <= '0;
            end
        end
        else if (clk_en && pair_ready)
        begin
            for (int i = 0; i < NUM_STATES; i++)
            begin
                path_reg[i] <= path_next[i];
            end
        end
    end

    // Steps taken since reset; released bits before the fill are start-up garbage
    assign filled = (fill_reg == FILL_DONE);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fill_reg <= '0;
        end
        else if (clk_en && pair_ready && !filled)
        begin
            fill_reg <= fill_reg + 1'b1;
        end
    end

    // Subcarrier loss timer; squelch engages once loss lasts SQUELCH_CYCLES, releases at once
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            loss_cnt_reg <= '0;
            squelch_active <= 1'b1;
        end
        else if (clk_en)
        begin
            if (subcarrier_ok)
            begin
                loss_cnt_reg <= '0;
                squelch_active <= 1'b0;
            end
            else if (loss_cnt_reg >= SQL_CNT_W'(SQUELCH_CYCLES - 1))
            begin
                squelch_active <= 1'b1;
            end
            else
            begin
                loss_cnt_reg <= loss_cnt_reg + 1'b1;
            end
        end
    end

    // Command outputs: one bit per pair, forced low under squelch or before the fill
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_data <= 1'b0;
            cmd_strobe <= 1'b0;
        end
        else if (clk_en)
        begin
            if (squelch_active || !subcarrier_ok && loss_cnt_reg >= SQL_CNT_W'(SQUELCH_CYCLES - 1))
            begin
                cmd_data <= 1'b0;
                cmd_strobe <= 1'b0;
            end
            else if (pair_ready && filled)
            begin
                cmd_data <= released_bit;
                cmd_strobe <= 1'b1;
            end
            else
            begin
                cmd_strobe <= 1'b0;
                cmd_data <= (pair_ready && filled) ? released_bit : cmd_data;
            end
        end
    end

    // Power mode follows carrier acquisition; standby again when the carrier drops
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_operate <= 1'b0;
        end
        else if (clk_en)
        begin
            power_operate <= carrier_acquired;
        end
    end

    // Symbol pacing check; only flags, since decoding itself is rate agnostic
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap_cnt_reg <= '0;
            sym_rate_fault <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sym_valid)
            begin
                gap_cnt_reg <= '0;
                sym_rate_fault <= sym_rate_fault || (gap_cnt_reg < GAP_CNT_W'(SYM_MIN_GAP - 1));
            end
            else if (gap_cnt_reg != '1)
            begin
                gap_cnt_reg <= gap_cnt_reg + 1'b1;
            end
        end
    end

endmodule // uplink_viterbi_command_decoder

/* File: uplink_viterbi_command_decoder_test.sv */
`timescale 1ns/1ps

module uplink_viterbi_command_decoder_test;
    import vd_pkg::*;
    localparam int SQ = 20;
    logic clk, sys_rst, clk_en, subcarrier_ok, carrier_acquired, sym_valid;
    logic [SYM_W-1:0] sym_data;
    logic cmd_data, cmd_strobe, squelch_active, power_operate, sym_rate_fault;
    int n_errors, tests_run, cyc;
    logic rx_q[$];
    logic tx[60];

    uplink_viterbi_command_decoder #(.SQUELCH_CYCLES(SQ), .SYM_MIN_GAP(2)) uut (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sym_valid(sym_valid), .sym_data(sym_data),
        .subcarrier_ok(subcarrier_ok), .carrier_acquired(carrier_acquired), .cmd_data(cmd_data),
        .cmd_strobe(cmd_strobe), .squelch_active(squelch_active), .power_operate(power_operate),
        .sym_rate_fault(sym_rate_fault));
    demod_model #(.GAP(4)) dm (.clk(clk), .sym_valid(sym_valid), .sym_data(sym_data));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Collect every decoded bit as it is strobed out
    always @(posedge clk)
    begin
        if (cmd_strobe === 1'b1)
            rx_q.push_back(cmd_data);
    end

    // Hang guard, well above the whole run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic test_reset();
        check({cmd_data, cmd_strobe, power_operate, sym_rate_fault}, 16'h0000);
        check(squelch_active, 16'h0001);
        $display("test_reset done");
    endtask

    // Power mode lags carrier by exactly one edge, both ways
    task automatic test_power();
        @(posedge clk) carrier_acquired <= 1'b1;
        #1 check(power_operate, 16'h0000);
        @(posedge clk) #1 check(power_operate, 16'h0001);
        carrier_acquired <= 1'b0;
        @(posedge clk) #1 check(power_operate, 16'h0000);
        $display("test_power done");
    endtask

    // Clock enable low freezes the power mode flop although the carrier changes
    task automatic test_freeze();
        @(posedge clk);
        clk_en <= 1'b0;
        carrier_acquired <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(power_operate, 16'h0000);
        @(posedge clk) clk_en <= 1'b1;
        @(posedge clk) #1 check(power_operate, 16'h0001);
        $display("test_freeze done");
    endtask

    // Back-to-back symbols set the sticky pacing fault
    task automatic test_rate_fault();
        check(sym_rate_fault, 16'h0000);
        dm.put_burst();
        #1 check(sym_rate_fault, 16'h0001);
        repeat (3) @(posedge clk);
        #1 check(sym_rate_fault, 16'h0001);
        $display("test_rate_fault done");
    endtask

    // 60 bits with one confident symbol error; 25 bits come out after the fill
    task automatic test_decode();
        @(posedge clk) subcarrier_ok <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 60; i++)
        begin
            tx[i] = ((i * 7 + 3) % 5) < 2;
            dm.send_bit(tx[i], i == 20);
        end
        repeat (4) @(posedge clk);
        check(rx_q.size(), 16'd25);
        for (int k = 0; k < rx_q.size(); k++)
            check(rx_q[k], tx[k]);
        check(sym_rate_fault, 16'h0000);
        $display("test_decode done");
    endtask

    // Subcarrier loss: squelch in time, outputs low, no bits leak out
    task automatic test_squelch();
        int n;
        int q;
        n = 0;
        @(posedge clk) subcarrier_ok <= 1'b0;
        while (squelch_active !== 1'b1 && n < 40)
        begin
            @(posedge clk) #1;
            n++;
        end
        check(n >= SQ - 1 && n <= SQ + 1, 16'h0001);
        check(cmd_data, 16'h0000);
        q = rx_q.size();
        for (int i = 0; i < 4; i++)
            dm.send_bit(i[0], 1'b0);
        check(rx_q.size(), q);
        @(posedge clk) subcarrier_ok <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(squelch_active, 16'h0000);
        $display("test_squelch done");
    endtask

    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        subcarrier_ok = 1'b0;
        carrier_acquired = 1'b0;
        n_errors = 0;
        tests_run = 0;
        cyc = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk) #1;
        test_reset();
        test_power();
        test_freeze();
        test_decode();
        test_squelch();
        test_rate_fault();
        finish_test();
    end
endmodule // uplink_viterbi_command_decoder_test

/* File: vd_checker_assertions.sv */
`timescale 1ns/1ps

// Port-level watch on strobe timing, squelch and power mode
module vd_checker
    import vd_pkg::*;
#(
    parameter int SQUELCH_CYCLES = 20,
    parameter int SYM_MIN_GAP = 2
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic sym_valid,
    input wire logic [vd_pkg::SYM_W-1:0] sym_data,
    input wire logic subcarrier_ok,
    input wire logic carrier_acquired,
    input wire logic cmd_data,
    input wire logic cmd_strobe,
    input wire logic squelch_active,
    input wire logic power_operate,
    input wire logic sym_rate_fault
);
    int lo_cnt;
    logic [6:0] sym_cnt;
    logic phase_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Run of low subcarrier samples; saturates so a long outage never wraps
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            lo_cnt <= 0;
        else if (clk_en)
            lo_cnt <= subcarrier_ok ? 0 : (lo_cnt > SQUELCH_CYCLES ? lo_cnt : lo_cnt + 1);
    end

    // Symbols taken since reset, held at 72, the pair after the 35-pair fill that releases the first bit
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sym_cnt <= 7'h00;
        else if (clk_en && sym_valid && sym_cnt < 7'h48)
            sym_cnt <= sym_cnt + 7'h01;
    end

    // High when the next symbol taken closes a pair
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            phase_reg <= 1'b0;
        else if (clk_en && sym_valid)
            phase_reg <= ~phase_reg;
    end

    sequence pair_end;
        clk_en && sym_valid && phase_reg;
    endsequence

    sequence unsquelched;
        !squelch_active && subcarrier_ok;
    endsequence

    a_strobe_one_cycle: assert property (cmd_strobe |=> !cmd_strobe)
        else $error("command strobe wider than one cycle");
    a_strobe_after_pair: assert property (cmd_strobe |-> $past(sym_valid) && !phase_reg)
        else $error("command strobe without a closing symbol");
    a_fill_delay_held: assert property (cmd_strobe |-> sym_cnt >= 7'h48)
        else $error("command bit released before the path delay");
    a_fill_output_due: assert property ((pair_end ##0 unsquelched ##0 sym_cnt >= 7'h47) |=> cmd_strobe)
        else $error("no command bit after a full pair");
    a_squelch_zero: assert property (squelch_active |-> !cmd_data && !cmd_strobe)
        else $error("command output active under squelch");
    a_squelch_within: assert property (lo_cnt > SQUELCH_CYCLES |-> squelch_active)
        else $error("squelch late after subcarrier loss");
    a_squelch_release: assert property ((clk_en && subcarrier_ok) |=> !squelch_active)
        else $error("squelch held with subcarrier present");
    a_data_held: assert property ((!cmd_strobe && !squelch_active) |-> $stable(cmd_data))
        else $error("command data changed without a strobe");
    a_power_follow: assert property (clk_en |=> power_operate == $past(carrier_acquired))
        else $error("power mode does not follow carrier");
endmodule // vd_checker

bind uplink_viterbi_command_decoder vd_checker #(.SQUELCH_CYCLES(SQUELCH_CYCLES), .SYM_MIN_GAP(SYM_MIN_GAP)) chk (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sym_valid(sym_valid), .sym_data(sym_data),
    .subcarrier_ok(subcarrier_ok), .carrier_acquired(carrier_acquired), .cmd_data(cmd_data),
    .cmd_strobe(cmd_strobe), .squelch_active(squelch_active), .power_operate(power_operate),
    .sym_rate_fault(sym_rate_fault)
);

/* File: vd_pkg.sv */
package vd_pkg;

    // Code shape
    localparam int CONSTRAINT_LEN = 7;
    localparam int STATE_W = CONSTRAINT_LEN - 1;
    localparam int NUM_STATES = 64;
    localparam int SYM_W = 3;
    localparam int METRIC_W = 4;
    localparam int SUM_W = METRIC_W + 1;
    localparam logic [METRIC_W-1:0] METRIC_MAX = 4'hf;
    localparam logic [METRIC_W-1:0] METRIC_RESET = 4'h0;
    localparam logic [SYM_W-1:0] SYM_MAX = 3'h7;

    // Generators, octal 171 and 133; bit 6 taps the newest input bit
    localparam logic [CONSTRAINT_LEN-1:0] POLY_A = 7'h79;
    localparam logic [CONSTRAINT_LEN-1:0] POLY_B = 7'h5b;

    // Survivor depth: five constraint lengths, plus the bit being released
    localparam int PATH_DELAY = 5 * CONSTRAINT_LEN;
    localparam int PATH_W = PATH_DELAY + 1;
    localparam int FILL_W = 6;
    localparam logic [FILL_W-1:0] FILL_DONE = 6'h23;

    // Rates and times
    localparam longint CLK_HZ = 200_000_000;
    localparam longint CMD_BIT_RATE = 2000;
    localparam longint SYM_RATE = 2 * CMD_BIT_RATE;
    localparam longint SQUELCH_MS = 15;
    // Longest time, rounded down
    localparam longint SQUELCH_CYC = (CLK_HZ * SQUELCH_MS) / 1000;
    localparam int SQL_CNT_W = 22;
    // Symbols closer than half the nominal spacing count as a rate fault
    localparam longint SYM_MIN_GAP_CYC = CLK_HZ / (2 * SYM_RATE);
    localparam int GAP_CNT_W = 16;

    // Expected code pair for a 7-bit encoder register {newest, ..., oldest}
    function automatic logic [1:0] encode(input logic [CONSTRAINT_LEN-1:0] enc_reg);
        encode = {^(enc_reg & POLY_A), ^(enc_reg & POLY_B)};
    endfunction

endpackage
